// ---- hdu_defines.vh ----
// Constants for the half-duplex 8-N-1 serial port: register map, fields, timing.
// Assumes a 32-bit Avalon-MM slave with word-aligned registers and a 250 MHz system clock.
`ifndef HDU_DEFINES_VH
`define HDU_DEFINES_VH

// ==========================================================
// Clock and line timing
`define HDU_CLK_HZ          250000000
`define HDU_BAUD_MIN        300
`define HDU_BAUD_MAX        57600
`define HDU_BAUD_DEFAULT    9600
`define HDU_DATA_BITS       8
`define HDU_STOP_BITS       1

// ==========================================================
// Register byte offsets
`define HDU_OFS_CTRL        5'h00
`define HDU_OFS_STATUS      5'h04
`define HDU_OFS_TXDATA      5'h08
`define HDU_OFS_RXDATA      5'h0c
`define HDU_OFS_BAUD        5'h10

// ==========================================================
// Control fields
`define HDU_CTRL_TXMODE     0
`define HDU_CTRL_START      1

// ==========================================================
// Status fields
`define HDU_ST_TXMODE       0
`define HDU_ST_TXBUSY       1
`define HDU_ST_RXBUSY       2
`define HDU_ST_RXFULL       3
`define HDU_ST_LOST         4
`define HDU_ST_ARMED        5

`endif

// ---- hdu_bit_timer.v ----
// Shared bit-interval timer, free running with reload and programmable start count.
// Assumes one system clock and a synchronous load strobe from the controller.
`timescale 1ns/1ns

module hdu_bit_timer
#(
   parameter W = 20
)
(
   clk,
   rst,
   enable,
   load,
   start_val,
   reload_val,
   tick
);
   input  wire         clk;
   input  wire         rst;
   input  wire         enable;
   input  wire         load;
   input  wire [W-1:0] start_val;
   input  wire [W-1:0] reload_val;
   output reg          tick;

   reg [W-1:0] cnt_reg;

   // ==========================================================
   // Counter
   // Ticks on reaching reload, then restarts from zero
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_reg <= {W{1'b0}};
         tick    <= 1'b0;
      end
      else if (load)
      begin
         cnt_reg <= start_val;
         tick    <= 1'b0;
      end
      else if (enable)
      begin
         if (cnt_reg + 1'b1 >= reload_val)
         begin
            cnt_reg <= {W{1'b0}};
            tick    <= 1'b1;
         end
         else
         begin
            cnt_reg <= cnt_reg + 1'b1;
            tick    <= 1'b0;
         end
      end
      else
         tick <= 1'b0;
   end
endmodule // hdu_bit_timer

// ---- hdu_uart.v ----
// Half-duplex 8-N-1 serial port with Avalon-MM register access.
// Assumes rx_line_pin is asynchronous and tx_line_pin drives an RS-232 level shifter.
`timescale 1ns/1ns
`include "hdu_defines.vh"

module hdu_uart
#(
   parameter CLK_HZ = `HDU_CLK_HZ,
   parameter BAUD   = `HDU_BAUD_DEFAULT,
   parameter TW     = 20
)
(
   clk_sys,
   rst_n,
   avs_address,
   avs_read,
   avs_write,
   avs_writedata,
   avs_readdata,
   avs_waitrequest,
   rx_line_pin,
   tx_line_pin,
   tx_line_oe
);
   input  wire        clk_sys;
   input  wire        rst_n;
   input  wire [4:0]  avs_address;
   input  wire        avs_read;
   input  wire        avs_write;
   input  wire [31:0] avs_writedata;
   output reg  [31:0] avs_readdata;
   output reg         avs_waitrequest;
   input  wire        rx_line_pin;
   output reg         tx_line_pin;
   output reg         tx_line_oe;

   // ==========================================================
   // States
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_RXST = 4'b0010;
   localparam [3:0] ST_RXD  = 4'b0100;
   localparam [3:0] ST_TX   = 4'b1000;

   // rounded reload for the default rate
   localparam integer RELOAD_DEF_I = (CLK_HZ + BAUD / 2) / BAUD;
   localparam integer RELOAD_MIN_I = (CLK_HZ + `HDU_BAUD_MAX / 2) / `HDU_BAUD_MAX;
   localparam integer RELOAD_MAX_I = (CLK_HZ + `HDU_BAUD_MIN / 2) / `HDU_BAUD_MIN;
   // Cut to the counter width on purpose; the slowest rate must still fit in TW bits
   localparam [TW-1:0] RELOAD_DEF = RELOAD_DEF_I[TW-1:0];
   localparam [TW-1:0] RELOAD_MIN = RELOAD_MIN_I[TW-1:0];
   localparam [TW-1:0] RELOAD_MAX = RELOAD_MAX_I[TW-1:0];

   // ==========================================================
   // Reset release
   reg rst_s1_reg;
   reg rst_s2_reg;
   wire rst = ~rst_s2_reg;

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end

   // ==========================================================
   // Receive pin synchroniser, three stages
   reg rx_s1_reg;
   reg rx_s2_reg;
   reg rx_s3_reg;
   reg rx_lvl_reg;

   // input with change accepted when stages two and three agree
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rx_s1_reg  <= 1'b1;
         rx_s2_reg  <= 1'b1;
         rx_s3_reg  <= 1'b1;
         rx_lvl_reg <= 1'b1;
      end
      else
      begin
         rx_s1_reg <= rx_line_pin;
         rx_s2_reg <= rx_s1_reg;
         rx_s3_reg <= rx_s2_reg;
         if (rx_s2_reg == rx_s3_reg)
            rx_lvl_reg <= rx_s3_reg;
      end
   end

   // ==========================================================
   // Registers and state
   reg [3:0]    state_reg;
   reg          txmode_reg;
   reg [TW-1:0] reload_reg;
   reg [7:0]    txdata_reg;
   reg [7:0]    txshift_reg;
   reg [7:0]    rxdata_reg;
   reg [7:0]    rxshift_reg;
   reg [3:0]    bitcnt_reg;
   reg          rxbusy_reg;
   reg          rxfull_reg;
   reg          lost_reg;
   reg          tmr_en_reg;
   reg          tmr_load_reg;
   reg [TW-1:0] tmr_start_reg;
   reg          tx_go_reg;
   reg          rx_prev_reg;

   wire tick;
   wire armed = (state_reg == ST_IDLE) && !txmode_reg;
   // falling edge seen only while armed
   wire fall  = armed && rx_prev_reg && !rx_lvl_reg;
   wire rx_rd = avs_read && avs_waitrequest && (avs_address == `HDU_OFS_RXDATA);
   // Writes land on the edge that samples waitrequest low, as the master expects
   wire wr_ok    = avs_write && !avs_waitrequest;
   wire wr_start = wr_ok && (avs_address == `HDU_OFS_CTRL) && avs_writedata[`HDU_CTRL_START];

   hdu_bit_timer #(.W(TW)) u_timer
   (
      .clk        (clk_sys),
      .rst        (rst),
      .enable     (tmr_en_reg),
      .load       (tmr_load_reg),
      .start_val  (tmr_start_reg),
      .reload_val (reload_reg),
      .tick       (tick)
   );

   // ==========================================================
   // Bus slave: one wait cycle, access completes on second edge
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end
      else if ((avs_read || avs_write) && avs_waitrequest)
      begin
         avs_waitrequest <= 1'b0;
         case (avs_address)
            `HDU_OFS_CTRL:   avs_readdata <= {31'h0, txmode_reg};
            `HDU_OFS_STATUS: avs_readdata <= {26'h0, armed, lost_reg, rxfull_reg,
                                              rxbusy_reg, state_reg == ST_TX, txmode_reg};
            `HDU_OFS_TXDATA: avs_readdata <= {24'h0, txdata_reg};
            `HDU_OFS_RXDATA: avs_readdata <= {24'h0, rxdata_reg};
            `HDU_OFS_BAUD:   avs_readdata <= {{(32-TW){1'b0}}, reload_reg};
            default:         avs_readdata <= 32'h0000_0000;
         endcase
      end
      else
         avs_waitrequest <= 1'b1;
   end

   // ==========================================================
   // Main sequencer
   always @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         state_reg     <= ST_IDLE;
         txmode_reg    <= 1'b0;
         reload_reg    <= RELOAD_DEF;
         txdata_reg    <= 8'h00;
         txshift_reg   <= 8'h00;
         rxdata_reg    <= 8'h00;
         rxshift_reg   <= 8'h00;
         bitcnt_reg    <= 4'h0;
         rxbusy_reg    <= 1'b0;
         rxfull_reg    <= 1'b0;
         lost_reg      <= 1'b0;
         tmr_en_reg    <= 1'b0;
         tmr_load_reg  <= 1'b0;
         tmr_start_reg <= {TW{1'b0}};
         tx_go_reg     <= 1'b0;
         rx_prev_reg   <= 1'b1;
         // output enabled and high out of reset
         tx_line_pin   <= 1'b1;
         tx_line_oe    <= 1'b1;
      end
      else
      begin
         tmr_load_reg <= 1'b0;
         rx_prev_reg  <= rx_lvl_reg;
         // reading the buffer clears full and lost flags
         if (rx_rd)
         begin
            rxfull_reg <= 1'b0;
            lost_reg   <= 1'b0;
         end
         // Register writes; mode only changes while idle to keep half duplex
         if (wr_ok)
         begin
            case (avs_address)
               `HDU_OFS_CTRL:
               begin
                  if (state_reg == ST_IDLE)
                     txmode_reg <= avs_writedata[`HDU_CTRL_TXMODE];
                  if (avs_writedata[`HDU_CTRL_START])
                     tx_go_reg <= 1'b1;
               end
               `HDU_OFS_TXDATA: txdata_reg <= avs_writedata[7:0];
               // rate reload clamped to the 300..57600 baud range
               `HDU_OFS_BAUD:
                  if (state_reg == ST_IDLE)
                  begin
                     if (avs_writedata[TW-1:0] < RELOAD_MIN)
                        reload_reg <= RELOAD_MIN;
                     else if (avs_writedata[TW-1:0] > RELOAD_MAX)
                        reload_reg <= RELOAD_MAX;
                     else
                        reload_reg <= avs_writedata[TW-1:0];
                  end
               default: ;
            endcase
         end
         case (state_reg)
            ST_IDLE:
            begin
               tx_line_pin <= 1'b1;
               tmr_en_reg  <= 1'b0;
               if (txmode_reg && tx_go_reg)
               begin
                  // A start written on this same edge stays pending
                  tx_go_reg     <= wr_start;
                  // start bit low, counter cleared then stepped
                  tx_line_pin   <= 1'b0;
                  bitcnt_reg    <= 4'h1;
                  txshift_reg   <= txdata_reg;
                  tmr_start_reg <= {TW{1'b0}};
                  tmr_load_reg  <= 1'b1;
                  tmr_en_reg    <= 1'b1;
                  state_reg     <= ST_TX;
               end
               // start edge enables timer and disarms detection
               else if (fall)
               begin
                  // start at half reload to hit mid start bit
                  tmr_start_reg <= {1'b0, reload_reg[TW-1:1]};
                  tmr_load_reg  <= 1'b1;
                  tmr_en_reg    <= 1'b1;
                  state_reg     <= ST_RXST;
               end
            end
            ST_RXST:
               if (tick)
               begin
                  // low confirms start, high abandons as glitch
                  if (!rx_lvl_reg)
                  begin
                     rxbusy_reg <= 1'b1;
                     bitcnt_reg <= 4'h0;
                     state_reg  <= ST_RXD;
                  end
                  else
                  begin
                     tmr_en_reg <= 1'b0;
                     state_reg  <= ST_IDLE;
                  end
               end
            ST_RXD:
               if (tick)
               begin
                  rxshift_reg <= {rx_lvl_reg, rxshift_reg[7:1]};
                  bitcnt_reg  <= bitcnt_reg + 4'h1;
                  if (bitcnt_reg == `HDU_DATA_BITS - 1)
                  begin
                     // stop timer, clear busy, back to armed idle
                     bitcnt_reg <= 4'h0;
                     tmr_en_reg <= 1'b0;
                     rxbusy_reg <= 1'b0;
                     rxdata_reg <= {rx_lvl_reg, rxshift_reg[7:1]};
                     // byte into buffer; set beats the read clear
                     rxfull_reg <= 1'b1;
                     if (rxfull_reg && !rx_rd)
                        lost_reg <= 1'b1;
                     else if (rxfull_reg && rx_rd)
                        lost_reg <= 1'b0;
                     state_reg  <= ST_IDLE;
                  end
               end
            ST_TX:
               if (tick)
               begin
                  bitcnt_reg <= bitcnt_reg + 4'h1;
                  // counts one to eight carry data, nine the stop bit
                  if (bitcnt_reg <= `HDU_DATA_BITS)
                  begin
                     tx_line_pin <= txshift_reg[0];
                     txshift_reg <= {1'b0, txshift_reg[7:1]};
                  end
                  // stop bit high after the eighth data bit
                  else if (bitcnt_reg == `HDU_DATA_BITS + 1)
                     tx_line_pin <= 1'b1;
                  else
                  begin
                     // stop held one interval, then timer off
                     tmr_en_reg <= 1'b0;
                     bitcnt_reg <= 4'h0;
                     state_reg  <= ST_IDLE;
                  end
               end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule // hdu_uart

// ---- hdu_uart_assertions.sv ----
// Checker for the serial port, fed from the top module ports only.
// Assumes one clock domain with active-low rst_n.
`timescale 1ns/1ns
// ==========================================
// Port protocol checker
module hdu_uart_chk
(
   input logic        clk_sys,
   input logic        rst_n,
   input logic        avs_read,
   input logic        avs_write,
   input logic [31:0] avs_readdata,
   input logic        avs_waitrequest,
   input logic        tx_line_pin,
   input logic        tx_line_oe
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // Pin drive at all times, idle level right after reset
   property p_oe;
      tx_line_oe;
   endproperty
   property p_rst_idle;
      $rose(rst_n) |-> tx_line_pin && avs_waitrequest;
   endproperty
   // Exactly one wait cycle, answer stands one cycle
   property p_ans;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   property p_pulse;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   property p_hold;
      !(avs_read || avs_write) |=> $stable(avs_readdata);
   endproperty
   // Bits are never shorter than a minimum interval
   property p_start;
      $fell(tx_line_pin) |-> !tx_line_pin [*8];
   endproperty
   property p_rise;
      $rose(tx_line_pin) |-> tx_line_pin [*8];
   endproperty
   // Nine low bits at most, so the line must come back high
   property p_frame;
      $fell(tx_line_pin) |-> ##[1:300] tx_line_pin;
   endproperty

   a_oe: assert property (p_oe) else $error("pin enable dropped");
   a_rst_idle: assert property (p_rst_idle) else $error("not idle at reset");
   a_ans: assert property (p_ans) else $error("no answer after one cycle");
   a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
   a_hold: assert property (p_hold) else $error("read data moved while idle");
   a_start: assert property (p_start) else $error("low bit too short");
   a_rise: assert property (p_rise) else $error("high bit too short");
   a_frame: assert property (p_frame) else $error("line stuck low");
   c_fall: cover property ($fell(tx_line_pin));
   c_rd: cover property (avs_read && !avs_waitrequest);
   c_wr: cover property (avs_write && !avs_waitrequest);
endmodule // hdu_uart_chk

// ---- hdu_pc_port.sv ----
// Model of the remote serial port behind the line driver.
// Assumes go or glitch pulse one cycle; bit_cyc is the bit time in clocks.
`timescale 1ns/1ns
// ==========================================
// Remote port model
module hdu_pc_port
(
   input  logic        clk_sys,
   input  logic [15:0] bit_cyc,
   input  logic        go,
   input  logic        glitch,
   input  logic [7:0]  tx_byte,
   input  logic        tx_line,
   output logic        rx_line,
   output logic        busy,
   output logic [7:0]  got_byte,
   output logic [7:0]  got_cnt,
   output logic        frame_err
);
   integer     i;
   integer     j;
   logic [7:0] sh;

   // Idle mark level on the line
   initial
   begin
      rx_line = 1'b1;
      busy = 1'b0;
      got_cnt = 8'h00;
      frame_err = 1'b0;
   end

   // Sender at the shared rate: start, eight bits LSB first, stop
   always
   begin
      @(posedge clk_sys);
      if (go)
      begin
         busy <= 1'b1;
         rx_line <= 1'b0;
         for (i = 0; i < 10; i++)
         begin
            repeat (bit_cyc) @(posedge clk_sys);
            rx_line <= (i < 8) ? tx_byte[i] : 1'b1;
         end
         busy <= 1'b0;
      end
      else if (glitch)
      begin
         rx_line <= 1'b0;
         repeat (3) @(posedge clk_sys);
         rx_line <= 1'b1;
      end
   end

   // Receiver realigns on each start edge, samples mid-bit
   always
   begin
      @(negedge tx_line);
      repeat (bit_cyc / 2) @(posedge clk_sys);
      if (tx_line !== 1'b0)
         frame_err <= 1'b1;
      for (j = 0; j < 9; j++)
      begin
         repeat (bit_cyc) @(posedge clk_sys);
         if (j < 8)
            sh[j] = tx_line;
         else if (tx_line !== 1'b1)
            frame_err <= 1'b1;
      end
      got_byte <= sh;
      got_cnt <= got_cnt + 8'h01;
   end
endmodule // hdu_pc_port

// ---- tb_hdu_uart.sv ----
// Self-checking bench for the half-duplex serial port.
// Assumes a slow system clock parameter so one bit is twenty clocks.
`timescale 1ns/1ns
// ==========================================
// Bench top
module tb_hdu_uart;
   localparam int CLK = 192000;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic [4:0]  avs_address = 5'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        rx_line_pin;
   logic        tx_line_pin;
   logic        tx_line_oe;
   logic [15:0] bit_cyc = 16'h14;
   logic        go = 1'b0;
   logic        glitch = 1'b0;
   logic [7:0]  tx_byte = 8'h00;
   logic [7:0]  got_byte;
   logic [7:0]  got_cnt;
   logic        frame_err;
   logic        busy;
   logic [31:0] rd;
   logic [31:0] seed = 32'h3f38;
   integer      err_count = 0;
   integer      samples_checked = 0;
   integer      k;

   always #2 clk_sys = ~clk_sys;

   hdu_uart #(.CLK_HZ(CLK), .BAUD(9600)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rx_line_pin(rx_line_pin),
      .tx_line_pin(tx_line_pin), .tx_line_oe(tx_line_oe));
   hdu_pc_port pc (.clk_sys(clk_sys), .bit_cyc(bit_cyc), .go(go), .glitch(glitch),
      .tx_byte(tx_byte), .tx_line(tx_line_pin), .rx_line(rx_line_pin), .busy(busy),
      .got_byte(got_byte), .got_cnt(got_cnt), .frame_err(frame_err));

   // Expected values: rounded reload and status word
   function automatic [31:0] reload(input int hz, input int baud);
      return (hz + baud / 2) / baud;
   endfunction
   function automatic [31:0] st(input logic t, b, f, l, a);
      return {26'h0, a, l, f, 1'b0, b, t};
   endfunction
   function automatic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
         err_count++;
      end
   endtask
   task limit(input integer n, input integer lim);
      if (n >= lim)
      begin
         $display("mismatch at %0t: wait ran out", $time);
         err_count++;
         tally_and_finish;
      end
   endtask
   // Bus cycle held until waitrequest is sampled low
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      integer n;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      limit(n, 20);
   endtask
   task rchk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // Remote port sends a frame, or a short glitch
   task send(input logic [7:0] b, input logic g);
      integer n;
      tx_byte <= b;
      go <= !g;
      glitch <= g;
      @(posedge clk_sys);
      go <= 1'b0;
      glitch <= 1'b0;
      repeat (2) @(posedge clk_sys);
      for (n = 0; busy === 1'b1 && n < 2000; n++)
         @(posedge clk_sys);
      limit(n, 2000);
      repeat (g ? 10 * bit_cyc : 8) @(posedge clk_sys);
   endtask
   // Load and start a transmit, compare what the remote port decoded
   task xmit(input logic [7:0] b);
      integer n;
      logic [7:0] c;
      c = got_cnt;
      bus(1'b1, 5'h08, {24'h0, b});
      bus(1'b1, 5'h00, 32'h3);
      rchk(5'h04, st(1, 1, 0, 0, 0));
      for (n = 0; got_cnt === c && n < 2000; n++)
         @(posedge clk_sys);
      limit(n, 2000);
      chk({24'h0, got_byte}, {24'h0, b});
      chk({31'h0, frame_err}, 32'h0);
      repeat (bit_cyc) @(posedge clk_sys);
      rchk(5'h04, st(1, 0, 0, 0, 0));
   endtask

   initial
   begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk({30'h0, tx_line_oe, tx_line_pin}, 32'h3);
      rchk(5'h10, reload(CLK, 9600));
      rchk(5'h04, st(0, 0, 0, 0, 1));
      bus(1'b1, 5'h14, 32'hffffffff);
      rchk(5'h14, 32'h0);
      for (k = 0; k < 4; k++)
      begin
         seed = xs(seed);
         send(seed[7:0], 1'b0);
         rchk(5'h04, st(0, 0, 1, 0, 1));
         rchk(5'h0c, {24'h0, seed[7:0]});
      end
      send(8'h00, 1'b1);
      rchk(5'h04, st(0, 0, 0, 0, 1));
      send(8'h00, 1'b0);
      send(8'hff, 1'b0);
      rchk(5'h04, st(0, 0, 1, 1, 1));
      rchk(5'h0c, 32'hff);
      rchk(5'h04, st(0, 0, 0, 0, 1));
      seed = xs(seed);
      xmit(seed[7:0]);
      send(8'h5a, 1'b0);
      rchk(5'h04, st(1, 0, 0, 0, 0));
      bus(1'b1, 5'h00, 32'h0);
      rchk(5'h04, st(0, 0, 0, 0, 1));
      bus(1'b1, 5'h10, 32'h1e);
      rchk(5'h10, 32'h1e);
      bit_cyc <= 16'h1e;
      seed = xs(seed);
      send(seed[7:0], 1'b0);
      rchk(5'h0c, {24'h0, seed[7:0]});
      xmit(8'h80);
      tally_and_finish;
   end
endmodule // tb_hdu_uart

bind hdu_uart hdu_uart_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .tx_line_pin(tx_line_pin), .tx_line_oe(tx_line_oe));
